// [logic/ust_pkg.sv]
// Purpose: shared constants for the microsecond timer with four alarms
// Assumes: single clock domain, tick pulse produced by logic on the same clock
// Notes: no software registers; control and status travel as plain ports
`default_nettype none

package ust_pkg;
  localparam int CNT_W = 64;            // full count width
  localparam int HALF_W = 32;           // bus and compare width
  localparam int NUM_ALARMS = 4;        // alarm count
  localparam int RD_SEL_W = 2;          // read selector width
  localparam logic [1:0] RD_LO_LATCH = 2'h0; // low half, latches high half
  localparam logic [1:0] RD_HI_HELD = 2'h1;  // high half from latch
  localparam logic [1:0] RD_LO_RAW = 2'h2;   // low half, no latching
  localparam logic [63:0] CNT_RST = 64'h0;   // count after reset
  localparam logic [31:0] HALF_RST = 32'h0;  // target, latch and read data reset
endpackage : ust_pkg

`default_nettype wire

// [logic/ust_alarm.sv]
// Purpose: one compare alarm with sticky interrupt and enable
// Assumes: strobes are one-cycle pulses on core_clk_i
// Notes: a write in the same cycle as a cancel wins and re-arms
`default_nettype none

module ust_alarm (
  input wire logic core_clk_i,                        // 40 MHz clock
  input wire logic rst_n_i,                           // async reset, low
  input wire logic clk_en_i,                          // freezes state when low
  input wire logic [ust_pkg::HALF_W-1:0] cnt_lo_i,    // low half of count
  input wire logic wr_i,                              // load target pulse
  input wire logic [ust_pkg::HALF_W-1:0] target_i,    // new target
  input wire logic cancel_i,                          // disarm pulse
  input wire logic force_i,                           // force interrupt pulse
  input wire logic clr_i,                             // write-one-to-clear
  input wire logic en_i,                              // interrupt enable level
  output logic armed_o,                               // alarm armed
  output logic irq_o                                  // interrupt, registered
);
  logic armed_r, armed_nxt;
  logic pend_r, pend_nxt;
  logic irq_r, irq_nxt;
  logic [ust_pkg::HALF_W-1:0] target_r, target_nxt;
  logic hit;

  // match only while armed; a cancel in the same cycle suppresses it
  always_comb begin
    hit = armed_r && !cancel_i && (cnt_lo_i == target_r);
    target_nxt = wr_i ? target_i : target_r;
    if (wr_i) begin
      armed_nxt = 1'b1;
    end else if (cancel_i || hit) begin
      armed_nxt = 1'b0;
    end else begin
      armed_nxt = armed_r;
    end
    // set wins over clear so an event in the clearing cycle is kept
    if (hit || force_i) begin
      pend_nxt = 1'b1;
    end else if (clr_i) begin
      pend_nxt = 1'b0;
    end else begin
      pend_nxt = pend_r;
    end
    irq_nxt = pend_nxt && en_i;
  end

  // state registers, frozen by the clock enable
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_r <= 1'b0;
      pend_r <= 1'b0;
      irq_r <= 1'b0;
      target_r <= ust_pkg::HALF_RST;
    end else if (clk_en_i) begin
      armed_r <= armed_nxt;
      pend_r <= pend_nxt;
      irq_r <= irq_nxt;
      target_r <= target_nxt;
    end
  end

  assign armed_o = armed_r;
  assign irq_o = irq_r;

  arm_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && wr_i |=> armed_r && target_r == $past(target_i))
    else $error("write did not arm alarm with new target");
  cancel_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && cancel_i && !wr_i && !force_i && !pend_r |=> !armed_r && !pend_r)
    else $error("cancelled alarm still armed or pending");
  match_fire_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && armed_r && !cancel_i && cnt_lo_i == target_r |=> pend_r)
    else $error("match did not set pending");
  self_disarm_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && hit && !wr_i |=> !armed_r)
    else $error("alarm stayed armed after match");
  force_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && force_i && en_i |=> irq_r ##1 (irq_r || $past(clr_i) || !$past(en_i)))
    else $error("forced interrupt not raised");
  sticky_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pend_r && !(clk_en_i && clr_i) |=> pend_r)
    else $error("pending dropped without clear");
  irq_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !en_i |=> !irq_r)
    else $error("disabled alarm raised interrupt");

  match_seen_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && hit && en_i ##1 irq_r);
  force_clear_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && force_i ##[1:4] clk_en_i && clr_i ##1 !pend_r);
endmodule : ust_alarm

`default_nettype wire

// [logic/ust_timer.sv]
// Purpose: free-running 64-bit microsecond counter with four compare alarms
// Assumes: tick_i is a one-cycle pulse from logic on core_clk_i
// Notes: read data appears one cycle after a read strobe, with rd_valid_o
// Notes: the high half is only coherent when read through the latch pair
// Notes: alarms compare the registered count every enabled cycle, so a
// target equal to the current low half fires on the very next edge
`default_nettype none

module ust_timer #(
  parameter int NUM_ALARMS = ust_pkg::NUM_ALARMS  // alarm count
) (
  input wire logic core_clk_i,                          // 40 MHz clock
  input wire logic rst_n_i,                             // async reset, low
  input wire logic clk_en_i,                            // freezes state when low
  input wire logic tick_i,                              // one-microsecond pulse
  input wire logic rd_req_i,                            // read strobe
  input wire logic [ust_pkg::RD_SEL_W-1:0] rd_sel_i,    // which half to read
  input wire logic [NUM_ALARMS-1:0] alm_wr_i,           // per-alarm target write
  input wire logic [ust_pkg::HALF_W-1:0] alm_target_i,  // target value
  input wire logic [NUM_ALARMS-1:0] alm_cancel_i,       // per-alarm cancel
  input wire logic [NUM_ALARMS-1:0] alm_force_i,        // per-alarm force
  input wire logic [NUM_ALARMS-1:0] irq_clr_i,          // write-one-to-clear
  input wire logic [NUM_ALARMS-1:0] irq_en_i,           // interrupt enables
  output logic [ust_pkg::HALF_W-1:0] rd_data_o,         // read data, registered
  output logic rd_valid_o,                              // read data valid pulse
  output logic [NUM_ALARMS-1:0] armed_o,                // alarm armed flags
  output logic [NUM_ALARMS-1:0] irq_o                   // one interrupt per alarm
);
  logic [ust_pkg::CNT_W-1:0] count_r, count_nxt;
  logic [ust_pkg::HALF_W-1:0] hi_hold_r, hi_hold_nxt;
  logic [ust_pkg::HALF_W-1:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;

  // half selectors for the read path; the alarm hookup slices count_r[31:0] itself
  function automatic logic [ust_pkg::HALF_W-1:0] lo_half(input logic [ust_pkg::CNT_W-1:0] c);
    return c[ust_pkg::HALF_W-1:0];
  endfunction

  function automatic logic [ust_pkg::HALF_W-1:0] hi_half(input logic [ust_pkg::CNT_W-1:0] c);
    return c[ust_pkg::CNT_W-1:ust_pkg::HALF_W];
  endfunction

  // counter: only ever steps up by one; full 64 bits never wrap in practice
  always_comb begin
    count_nxt = count_r;
    if (tick_i) begin
      count_nxt = count_r + 64'h1;
    end
  end

  // read path: a latching low read snapshots the high half for the pair
  always_comb begin
    hi_hold_nxt = hi_hold_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    if (rd_req_i) begin
      rd_valid_nxt = 1'b1;
      unique case (rd_sel_i)
        ust_pkg::RD_LO_LATCH: begin
          rd_data_nxt = lo_half(count_r);
          hi_hold_nxt = hi_half(count_r);
        end
        ust_pkg::RD_HI_HELD: begin
          rd_data_nxt = hi_hold_r;
        end
        ust_pkg::RD_LO_RAW: begin
          rd_data_nxt = lo_half(count_r);
        end
        default: begin
          rd_data_nxt = ust_pkg::HALF_RST; // unused selector reads zero
        end
      endcase
    end
  end

  // counter and read registers, all frozen by the clock enable
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= ust_pkg::CNT_RST;
      hi_hold_r <= ust_pkg::HALF_RST;
      rd_data_r <= ust_pkg::HALF_RST;
      rd_valid_r <= 1'b0;
    end else if (clk_en_i) begin
      count_r <= count_nxt;
      hi_hold_r <= hi_hold_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;

  // one alarm per interrupt line, all comparing the low half
  for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
    ust_alarm u_alarm (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .cnt_lo_i(count_r[31:0]),
      .wr_i(alm_wr_i[g]),
      .target_i(alm_target_i),
      .cancel_i(alm_cancel_i[g]),
      .force_i(alm_force_i[g]),
      .clr_i(irq_clr_i[g]),
      .en_i(irq_en_i[g]),
      .armed_o(armed_o[g]),
      .irq_o(irq_o[g])
    );

    // a force with the enable set must show on this line next edge
    force_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && alm_force_i[g] && irq_en_i[g] |=> irq_o[g])
      else $error("forced interrupt missing on its own line");
    // a cancel without a write must leave the alarm disarmed
    cancel_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && alm_cancel_i[g] && !alm_wr_i[g] |=> !armed_o[g])
      else $error("cancel left alarm armed");
    // with nothing able to set it, a clear must drop the line
    clear_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && irq_clr_i[g] && !alm_force_i[g] && !armed_o[g] |=> !irq_o[g])
      else $error("interrupt survived its clear");
  end

  count_inc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && tick_i |=> count_r == $past(count_r) + 64'h1)
    else $error("count did not step by one on tick");
  count_mono_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(clk_en_i && tick_i) |=> count_r == $past(count_r))
    else $error("count changed without a tick");
  latch_pair_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && rd_req_i && rd_sel_i == ust_pkg::RD_LO_LATCH
    ##1 clk_en_i && rd_req_i && rd_sel_i == ust_pkg::RD_HI_HELD
    |=> rd_valid_o && rd_data_o == $past(count_r[63:32], 2))
    else $error("high half not from latched snapshot");
  raw_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && rd_req_i && rd_sel_i == ust_pkg::RD_LO_RAW
    |=> rd_valid_o && rd_data_o == $past(count_r[31:0]) && $stable(hi_hold_r))
    else $error("raw low read wrong or disturbed latch");

  // valid is a single pulse: no request, no valid
  rd_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !rd_req_i |=> !rd_valid_o)
    else $error("read valid without a request");
  // every accepted request answers on the next edge
  rd_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && rd_req_i |=> rd_valid_o)
    else $error("read request not answered");
  // the unused selector must read zero, never stale data
  sel_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && rd_req_i && rd_sel_i == 2'h3 |=> rd_data_o == ust_pkg::HALF_RST)
    else $error("unused selector returned data");
  // only a latching low read may touch the held high half
  latch_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !(rd_req_i && rd_sel_i == ust_pkg::RD_LO_LATCH) |=> $stable(hi_hold_r))
    else $error("latched high half disturbed");
  // the latch takes the high half of the same instant as the low read
  latch_take_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && rd_req_i && rd_sel_i == ust_pkg::RD_LO_LATCH
    |=> hi_hold_r == $past(count_r[63:32]))
    else $error("latch missed the high half");
  // a low enable freezes the count, read data, interrupt lines and armed flags
  freeze_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !clk_en_i |=> $stable(count_r) && $stable(rd_data_o) && $stable(irq_o) && $stable(armed_o))
    else $error("state moved with clock enable low");
  // the low half wraps to zero on a tick from all ones
  low_wrap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && tick_i && count_r[31:0] == 32'hffffffff |=> count_r[31:0] == 32'h0)
    else $error("low half did not wrap to zero");
  // no carry, no change in the high half
  hi_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && tick_i && count_r[31:0] != 32'hffffffff
    |=> count_r[63:32] == $past(count_r[63:32]))
    else $error("high half moved without a carry");
  // the full count never goes backwards
  count_up_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> count_r >= $past(count_r))
    else $error("count went backwards");
  // a masked alarm never shows on its line
  irq_masked_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> (irq_o & ~$past(irq_en_i)) == '0)
    else $error("masked alarm raised its line");
  // every written alarm is armed on the next edge
  arm_all_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && |alm_wr_i |=> (armed_o & $past(alm_wr_i)) == $past(alm_wr_i))
    else $error("written alarm not armed");

  pair_read_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_req_i && rd_sel_i == ust_pkg::RD_LO_LATCH ##[1:8] rd_req_i
    && rd_sel_i == ust_pkg::RD_HI_HELD);
  low_wrap_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && tick_i && count_r[31:0] == 32'hffffffff);
  any_irq_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) |irq_o);
endmodule : ust_timer

`default_nettype wire

// [verif/ust_tick_gen.sv]
// Purpose: far-side model of the one-microsecond tick source
// Assumes: same clock as the timer, so no synchroniser is needed
// Notes: PERIOD sets how often ticks land; run_i low holds it quiet
`default_nettype none

module ust_tick_gen #(
  parameter int PERIOD = 3  // clocks per tick, shortened from 40
) (
  input wire logic core_clk_i,  // 40 MHz clock
  input wire logic rst_n_i,     // async reset, low
  input wire logic run_i,       // ticks only while high
  output logic tick_o           // one-cycle tick pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_r;

  // divider: a short period keeps alarm waits brief
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 0;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= (run_i && cnt_r < PERIOD - 1) ? cnt_r + 1 : 0;
      tick_o <= run_i && (cnt_r == PERIOD - 1);
    end
  end
endmodule // ust_tick_gen

`default_nettype wire

// [verif/ust_timer_tb_top.sv]
// Purpose: self-checking bench for the microsecond timer
// Assumes: ticks come from ust_tick_gen every third clock
// Notes: count rollover past 32 bits cannot be reached in a run
`default_nettype none

module ust_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic run = 1'b0;
  logic rd_req = 1'b0;
  logic [1:0] rd_sel = 2'h0;
  logic [3:0] wr = 4'h0, cncl = 4'h0, frc = 4'h0, clr = 4'h0, en = 4'h0, armed, irq;
  logic [31:0] tgt = 32'h0, rd_data, hi_latch = 32'h0;
  logic [63:0] exp_cnt;
  logic tick, rd_valid;
  int num_errors = 0;
  int cmp_count = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  ust_tick_gen #(.PERIOD(3)) tgen (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .run_i(run), .tick_o(tick));
  ust_timer dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .tick_i(tick), .rd_req_i(rd_req), .rd_sel_i(rd_sel), .alm_wr_i(wr),
    .alm_target_i(tgt), .alm_cancel_i(cncl), .alm_force_i(frc), .irq_clr_i(clr),
    .irq_en_i(en), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .armed_o(armed),
    .irq_o(irq));

  // reference count: a tick is lost while the clock enable is low
  always @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i) exp_cnt <= 64'h0;
    else if (clk_en_i && tick) exp_cnt <= exp_cnt + 64'h1;

  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic [3:0] got, input logic [3:0] exp);
    chk_d({28'h0, got}, {28'h0, exp});
  endtask

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one read; expectation taken before the sampling edge's tick lands
  task automatic rd(input logic [1:0] sel);
    logic [31:0] e;
    @(negedge core_clk_i);
    e = (sel == 2'h1) ? hi_latch : (sel == 2'h3) ? 32'h0 : exp_cnt[31:0];
    if (sel == 2'h0) hi_latch = exp_cnt[63:32];
    rd_req = 1'b1;
    rd_sel = sel;
    @(negedge core_clk_i);
    rd_req = 1'b0;
    chk_f({3'h0, rd_valid}, 4'h1);
    chk_d(rd_data, e);
  endtask

  // one-cycle strobes on the alarm command port
  task automatic drv(input logic [3:0] w, c, f, k, input logic [31:0] t);
    @(negedge core_clk_i);
    {wr, cncl, frc, clr, tgt} = {w, c, f, k, t};
    @(negedge core_clk_i);
    {wr, cncl, frc, clr} = 16'h0;
  endtask

  // bounded wait for alarm n to disarm itself by matching
  task automatic wait_fire(input int n);
    int i;
    for (i = 0; i < 300 && armed[n] !== 1'b0; i++) @(negedge core_clk_i);
    if (i == 300) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic s_read();
    run = 1'b1;
    for (int i = 0; i < 4; i++) rd(2'(i));
    repeat (7) @(negedge core_clk_i);
    clk_en_i = 1'b0;
    repeat (9) @(negedge core_clk_i);
    clk_en_i = 1'b1;
    rd(2'h2);
    rd(2'h0);
    rd(2'h1);
  endtask

  task automatic s_alarms();
    logic [31:0] t [4];
    en = 4'hf;
    for (int n = 0; n < 4; n++) t[n] = exp_cnt[31:0] + 32'(4 * n + 8);
    drv(4'h1, 4'h0, 4'h0, 4'h0, t[0] + 32'h3e8);
    for (int n = 0; n < 4; n++) drv(4'(1 << n), 4'h0, 4'h0, 4'h0, t[n]);
    chk_f(armed, 4'hf);
    for (int n = 0; n < 4; n++) begin
      wait_fire(n);
      chk_d(exp_cnt[31:0], t[n]);
      chk_f(irq, 4'(~(4'he << n)));
    end
    repeat (5) @(negedge core_clk_i);
    chk_f(armed, 4'h0);
    drv(4'h0, 4'h0, 4'h0, 4'h2, 32'h0);
    chk_f(irq, 4'hd);
    drv(4'h0, 4'h0, 4'h0, 4'hf, 32'h0);
    chk_f(irq, 4'h0);
  endtask

  task automatic s_cancel_mask_force();
    drv(4'h4, 4'h0, 4'h0, 4'h0, exp_cnt[31:0] + 32'h4);
    drv(4'h0, 4'h4, 4'h0, 4'h0, 32'h0);
    chk_f(armed, 4'h0);
    repeat (30) @(negedge core_clk_i);
    chk_f(irq, 4'h0);
    en = 4'h7;
    drv(4'h8, 4'h0, 4'h0, 4'h0, exp_cnt[31:0] + 32'h3);
    wait_fire(3);
    chk_f(irq, 4'h0);
    en = 4'hf;
    @(negedge core_clk_i);
    chk_f(irq, 4'h8);
    drv(4'h0, 4'h0, 4'h5, 4'h8, 32'h0);
    chk_f(irq, 4'h5);
    chk_f(armed, 4'h0);
  endtask

  initial begin
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk_f({3'h0, rd_valid} | armed | irq, 4'h0);
    s_read();
    s_alarms();
    s_cancel_mask_force();
    print_verdict();
  end
endmodule // ust_timer_tb_top

`default_nettype wire
